// ### rtl/adcp_pkg.sv
// Constants shared by the converter host-port control logic
package adcp_pkg;
	// ==========================================================
	// Configuration word layout
	localparam int CFG_WIDTH    = 12;
	localparam int CFG_PM_HI    = 11;
	localparam int CFG_PM_LO    = 10;
	localparam int CFG_CODING   = 9;
	localparam int CFG_REF      = 8;
	localparam int CFG_ADDR_HI  = 6;
	localparam int CFG_ADDR_LO  = 5;
	localparam int CFG_MODE_HI  = 4;
	localparam int CFG_MODE_LO  = 3;
	localparam int CFG_SEQ_HI   = 2;
	localparam int CFG_SEQ_LO   = 1;
	localparam int CFG_RANGE    = 0;
	localparam logic [11:0] CFG_RESET = 12'h000;

	// ==========================================================
	// Input arrangement codes
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_DIFF   = 2'h1;
	localparam logic [1:0] MODE_PSEUDO = 2'h2;

	// Power mode codes; zero is normal operation
	localparam logic [1:0] PM_NORMAL = 2'h0;

	// ==========================================================
	// Conversion timing: half master-clock cycles per conversion
	localparam int CONV_HALF_CYCLES = 27;
	localparam int CONV_CYCLES      = (CONV_HALF_CYCLES + 1) / 2;
	localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);

	// Result FIFO depth
	localparam int RES_FIFO_DEPTH = 8;

	typedef enum logic {ADCP_TRACK, ADCP_CONVERT} adcp_state_e;
endpackage

// ### rtl/adcp_host_ctrl.sv
// Host-port control of a four-input converter, with its result FIFO
// Functional notes
// - Configuration loads only on a write strobe while chip select is low.
// - A qualified read drives the oldest result in the FIFO onto the data bus.
// - Arrangement bits pick four single, two differential or two pseudo pairs.
// - Channel comes from address bits or from the sequencer when enabled.
// - Range bit sets one span, reference or twice reference, for all inputs.
// - Coding bit selects straight binary or twos complement results.
// - Track-and-hold returns to tracking at the end of each conversion.
// - Start falling edge holds and converts unless the FIFO is full; rising edge powers up auto modes.
// - Busy rises after start, stays through conversion, falls with result stored.
// - Conversion lasts thirteen and a half master clocks, rounded up here.
// - Configuration is twelve bits, write-only, all zero after reset.
`timescale 1ns/1ns

// ==========================================================
// Result FIFO
module adcp_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk_in,
	input  wire logic             srst_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	input  wire logic [WIDTH-1:0] wr_data_in,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	output logic      [WIDTH-1:0] rd_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Refuse shapes the wrapping pointers cannot serve
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
	begin
		$error("adcp_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wp_reg;
	logic [AW-1:0]    wp_next;
	logic [AW-1:0]    rp_reg;
	logic [AW-1:0]    rp_next;
	logic [AW:0]      cnt_reg;
	logic [AW:0]      cnt_next;
	logic             push;
	logic             pop;

	// Handshakes and honest full/empty
	assign wr_ready_out = (cnt_reg != (AW+1)'(DEPTH));
	assign rd_valid_out = (cnt_reg != '0);
	assign rd_data_out  = mem_reg[rp_reg];
	assign push         = wr_valid_in && wr_ready_out;
	assign pop          = rd_ready_in && rd_valid_out;

	// Pointer and count next values
	always_comb
	begin
		wp_next  = push ? wp_reg + 1'b1 : wp_reg;
		rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
		cnt_next = cnt_reg;
		if (push && !pop)
			cnt_next = cnt_reg + 1'b1;
		else if (pop && !push)
			cnt_next = cnt_reg - 1'b1;
	end

	// Pointer registers
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage
	always_ff @(posedge mclk_in)
	begin
		if (push)
			mem_reg[wp_reg] <= wr_data_in;
	end
endmodule

// ==========================================================
// Control top
module adcp_host_ctrl
	import adcp_pkg::*;
#(
	parameter int DATA_WIDTH = CFG_WIDTH,
	parameter int FIFO_DEPTH = RES_FIFO_DEPTH
) (
	input  wire logic                  mclk_in,
	input  wire logic                  srst_in,
	input  wire logic                  cs_n_in,
	input  wire logic                  rd_n_in,
	input  wire logic                  wr_n_in,
	input  wire logic [CFG_WIDTH-1:0]  data_in,
	output logic      [DATA_WIDTH-1:0] data_out,
	output logic                       data_oe_out,
	output logic      [1:0]            result_channel_out,
	input  wire logic                  conversion_start_n_in,
	output logic                       busy_out,
	output logic                       hold_out,
	input  wire logic [DATA_WIDTH-1:0] sar_code_in,
	output logic      [1:0]            mux_pos_out,
	output logic      [1:0]            mux_neg_out,
	output logic                       neg_to_ground_out,
	output logic                       range_double_out,
	output logic                       internal_ref_out,
	output logic      [1:0]            power_mode_out,
	output logic                       powered_up_out,
	output logic                       result_avail_out
);
	localparam int RW = DATA_WIDTH + 2;

	// Refuse a result width other than the configuration width
	if (DATA_WIDTH != CFG_WIDTH)
	begin
		$error("adcp_host_ctrl: DATA_WIDTH must equal the configuration width");
	end

	// ==========================================================
	// Declarations
	adcp_state_e            state_reg;
	adcp_state_e            state_next;
	logic [CFG_WIDTH-1:0]   cfg_reg;
	logic [CFG_WIDTH-1:0]   cfg_next;
	logic                   wr_n_d_reg;
	logic                   rd_n_d_reg;
	logic                   start_n_d_reg;
	logic [3:0]             cnt_reg;
	logic [3:0]             cnt_next;
	logic [1:0]             ch_reg;
	logic [1:0]             ch_next;
	logic [1:0]             seq_ch_reg;
	logic [1:0]             seq_ch_next;
	logic                   pwr_reg;
	logic                   pwr_next;
	logic [DATA_WIDTH-1:0]  dout_reg;
	logic [DATA_WIDTH-1:0]  dout_next;
	logic [1:0]             rch_reg;
	logic [1:0]             rch_next;
	logic                   wr_fall;
	logic                   rd_fall;
	logic                   start_fall;
	logic                   start_rise;
	logic                   seq_en;
	logic [1:0]             cfg_addr;
	logic [1:0]             cfg_mode;
	logic                   done;
	logic                   res_push;
	logic                   res_ready;
	logic                   res_valid;
	logic                   res_pop;
	logic [RW-1:0]          res_word;
	logic [RW-1:0]          res_head;
	logic [DATA_WIDTH-1:0]  coded;

	// ==========================================================
	// Strobe edge detection; read and write qualified by chip select, start not
	assign wr_fall    = wr_n_d_reg && !wr_n_in && !cs_n_in;
	assign rd_fall    = rd_n_d_reg && !rd_n_in && !cs_n_in;
	assign start_fall = start_n_d_reg && !conversion_start_n_in;
	assign start_rise = !start_n_d_reg && conversion_start_n_in;

	// Configuration field views
	assign cfg_addr = cfg_reg[CFG_ADDR_HI:CFG_ADDR_LO];
	assign cfg_mode = cfg_reg[CFG_MODE_HI:CFG_MODE_LO];
	assign seq_en   = cfg_reg[CFG_SEQ_HI];
	assign done     = (state_reg == ADCP_CONVERT) && (cnt_reg == CONV_LAST);

	// ==========================================================
	// Configuration and sequencer next values
	always_comb
	begin
		cfg_next    = cfg_reg;
		seq_ch_next = seq_ch_reg;
		pwr_next    = pwr_reg;
		if (wr_fall)
		begin
			cfg_next    = data_in;
			seq_ch_next = 2'h0;
		end
		else if (done && seq_en)
			seq_ch_next = (seq_ch_reg == cfg_addr) ? 2'h0 : seq_ch_reg + 2'h1;
		// Auto power modes sleep after a conversion, wake on start rising
		if (cfg_reg[CFG_PM_HI:CFG_PM_LO] == PM_NORMAL || start_rise)
			pwr_next = 1'b1;
		else if (done)
			pwr_next = 1'b0;
	end

	// ==========================================================
	// Conversion state machine next values
	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		ch_next    = ch_reg;
		case (state_reg)
			ADCP_TRACK:
			begin
				// A full FIFO refuses new conversion starts
				if (start_fall && res_ready)
				begin
					state_next = ADCP_CONVERT;
					cnt_next   = 4'h0;
					ch_next    = seq_en ? seq_ch_reg : cfg_addr;
				end
			end
			ADCP_CONVERT:
			begin
				cnt_next = cnt_reg + 4'h1;
				if (done)
					state_next = ADCP_TRACK;
			end
			default:
				state_next = ADCP_TRACK;
		endcase
	end

	// Output coding: twos complement flips the sign bit
	always_comb
	begin
		coded = sar_code_in;
		if (cfg_reg[CFG_CODING])
			coded[DATA_WIDTH-1] = ~sar_code_in[DATA_WIDTH-1];
	end

	assign res_word = {ch_reg, coded};
	assign res_push = done;

	// Read register next values
	always_comb
	begin
		dout_next = dout_reg;
		rch_next  = rch_reg;
		if (rd_fall && res_valid)
		begin
			dout_next = res_head[DATA_WIDTH-1:0];
			rch_next  = res_head[RW-1:DATA_WIDTH];
		end
	end
	assign res_pop = rd_fall;

	// ==========================================================
	// Registers
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			state_reg     <= ADCP_TRACK;
			cfg_reg       <= CFG_RESET;
			wr_n_d_reg    <= 1'b1;
			rd_n_d_reg    <= 1'b1;
			start_n_d_reg <= 1'b1;
			cnt_reg       <= 4'h0;
			ch_reg        <= 2'h0;
			seq_ch_reg    <= 2'h0;
			pwr_reg       <= 1'b1;
			dout_reg      <= '0;
			rch_reg       <= 2'h0;
		end
		else
		begin
			state_reg     <= state_next;
			cfg_reg       <= cfg_next;
			wr_n_d_reg    <= wr_n_in;
			rd_n_d_reg    <= rd_n_in;
			start_n_d_reg <= conversion_start_n_in;
			cnt_reg       <= cnt_next;
			ch_reg        <= ch_next;
			seq_ch_reg    <= seq_ch_next;
			pwr_reg       <= pwr_next;
			dout_reg      <= dout_next;
			rch_reg       <= rch_next;
		end
	end

	// ==========================================================
	// Result FIFO between converter and host port
	adcp_fifo #(
		.WIDTH (RW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk_in      (mclk_in),
		.srst_in      (srst_in),
		.wr_valid_in  (res_push),
		.wr_ready_out (res_ready),
		.wr_data_in   (res_word),
		.rd_valid_out (res_valid),
		.rd_ready_in  (res_pop),
		.rd_data_out  (res_head)
	);

	// ==========================================================
	// Analog front-end steering
	always_comb
	begin
		mux_pos_out       = ch_reg;
		mux_neg_out       = 2'h0;
		neg_to_ground_out = 1'b1;
		if (cfg_mode == MODE_DIFF || cfg_mode == MODE_PSEUDO)
		begin
			mux_pos_out       = {ch_reg[0], 1'b0};
			mux_neg_out       = {ch_reg[0], 1'b1};
			neg_to_ground_out = 1'b0;
		end
	end

	// Port outputs
	assign busy_out           = (state_reg == ADCP_CONVERT);
	assign hold_out           = (state_reg == ADCP_CONVERT);
	assign data_out           = dout_reg;
	assign data_oe_out        = !cs_n_in && !rd_n_in;
	assign result_channel_out = rch_reg;
	assign range_double_out   = cfg_reg[CFG_RANGE];
	assign internal_ref_out   = cfg_reg[CFG_REF];
	assign power_mode_out     = cfg_reg[CFG_PM_HI:CFG_PM_LO];
	assign powered_up_out     = pwr_reg;
	assign result_avail_out   = res_valid;
endmodule

// ### testbench/adcp_host_ctrl_props.sv
// Concurrent checks on the host-port control ports
`timescale 1ns/1ns
// ==========================================================
// Checker
module adcp_host_ctrl_props (
	input wire logic        mclk_in,
	input wire logic        srst_in,
	input wire logic        cs_n_in,
	input wire logic        rd_n_in,
	input wire logic        wr_n_in,
	input wire logic [11:0] data_in,
	input wire logic        data_oe_out,
	input wire logic        conversion_start_n_in,
	input wire logic        busy_out,
	input wire logic        hold_out,
	input wire logic        neg_to_ground_out,
	input wire logic        range_double_out,
	input wire logic        internal_ref_out,
	input wire logic [1:0]  power_mode_out,
	input wire logic        result_avail_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (srst_in);

	oe_drive_a: assert property (data_oe_out == (!cs_n_in && !rd_n_in))
		else $error("data bus enable wrong");
	cfg_load_a: assert property ($fell(wr_n_in) && !cs_n_in |=>
		{power_mode_out, internal_ref_out, range_double_out}
		== {$past(data_in[11:10]), $past(data_in[8]), $past(data_in[0])})
		else $error("config word not loaded");
	cfg_hold_a: assert property (!($fell(wr_n_in) && !cs_n_in) |=>
		$stable({power_mode_out, internal_ref_out, range_double_out}))
		else $error("config changed without write");
	neg_mode_a: assert property ($fell(wr_n_in) && !cs_n_in |=>
		neg_to_ground_out == ($past(data_in[4]) == $past(data_in[3])))
		else $error("input arrangement wrong");
	busy_rise_a: assert property ($rose(busy_out) |->
		$past(conversion_start_n_in, 2) && !$past(conversion_start_n_in))
		else $error("busy rose without start edge");
	busy_len_a: assert property ($rose(busy_out) |->
		busy_out [*8] ##1 busy_out [*6] ##1 !busy_out)
		else $error("conversion length wrong");
	hold_track_a: assert property (hold_out == busy_out)
		else $error("hold not matching conversion");
	result_push_a: assert property ($fell(busy_out) |-> result_avail_out)
		else $error("no result after conversion");
	busy_idle_a: assert property (!busy_out && !$fell(conversion_start_n_in) |=> !busy_out)
		else $error("busy without start edge");
endmodule

bind adcp_host_ctrl adcp_host_ctrl_props chk (.mclk_in, .srst_in, .cs_n_in, .rd_n_in,
	.wr_n_in, .data_in, .data_oe_out, .conversion_start_n_in, .busy_out, .hold_out,
	.neg_to_ground_out, .range_double_out, .internal_ref_out, .power_mode_out,
	.result_avail_out);

// ### testbench/adcp_host_model.sv
// Host processor model driving the parallel port
`timescale 1ns/1ns
// ==========================================================
// Host model
module adcp_host_model (
	input  wire logic        mclk_in,
	input  wire logic [11:0] rd_data_in,
	output logic             cs_n_out,
	output logic             rd_n_out,
	output logic             wr_n_out,
	output logic      [11:0] bus_data_out,
	output logic             start_n_out
);
	// Idle bus at time zero
	initial
	begin
		{cs_n_out, rd_n_out, wr_n_out, start_n_out} = 4'hF;
		bus_data_out = 12'hA5A;
	end

	// One write strobe; released bus shows inverted data
	task automatic write_cfg(input logic cs_n, input logic [11:0] w);
		@(negedge mclk_in);
		cs_n_out = cs_n;
		wr_n_out = 1'b0;
		bus_data_out = w;
		@(negedge mclk_in);
		{cs_n_out, wr_n_out} = 2'h3;
		bus_data_out = ~w;
	endtask

	// One qualified read, data taken a cycle later
	task automatic read_word(output logic [11:0] d);
		@(negedge mclk_in);
		{cs_n_out, rd_n_out} = 2'h0;
		@(negedge mclk_in);
		d = rd_data_in;
		{cs_n_out, rd_n_out} = 2'h3;
	endtask

	// Start pulse one cycle low
	task automatic start_conv();
		@(negedge mclk_in);
		start_n_out = 1'b0;
		@(negedge mclk_in);
		start_n_out = 1'b1;
	endtask
endmodule

// ### testbench/adcp_host_ctrl_bench.sv
// Self-checking bench for the converter host-port control
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
// ==========================================================
// Bench top
module adcp_host_ctrl_bench;
	import adcp_pkg::*;
	typedef struct {logic cs_n; logic [11:0] w; logic [4:0] e;} adcp_row_s;
	logic        mclk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic [11:0] sar_code = 12'h000;
	logic [11:0] bus_data, dout, word;
	logic [1:0]  chan, pm, mpos, mneg;
	logic        cs_n, rd_n, wr_n, start_n, oe, busy, hold, neg, rng, iref, pwr, avail;
	int          miscompares = 0;
	int          cmp_count = 0;
	adcp_row_s   rows [5] = '{'{1'b0, 12'hD09, 5'h1E}, '{1'b0, 12'h010, 5'h00},
		'{1'b0, 12'h018, 5'h01}, '{1'b0, 12'h000, 5'h01}, '{1'b1, 12'hD09, 5'h01}};

	adcp_host_ctrl DUT (.mclk_in(mclk_in), .srst_in(srst_in), .cs_n_in(cs_n),
		.rd_n_in(rd_n), .wr_n_in(wr_n), .data_in(bus_data), .data_out(dout),
		.data_oe_out(oe), .result_channel_out(chan), .conversion_start_n_in(start_n),
		.busy_out(busy), .hold_out(hold), .sar_code_in(sar_code), .mux_pos_out(mpos),
		.mux_neg_out(mneg), .neg_to_ground_out(neg), .range_double_out(rng),
		.internal_ref_out(iref), .power_mode_out(pm), .powered_up_out(pwr),
		.result_avail_out(avail));
	adcp_host_model host (.mclk_in(mclk_in), .rd_data_in(dout), .cs_n_out(cs_n),
		.rd_n_out(rd_n), .wr_n_out(wr_n), .bus_data_out(bus_data), .start_n_out(start_n));

	// Clock, 50 ns period
	initial
	begin
		forever #25 mclk_in = ~mclk_in;
	end

	// Verdict and end of run
	task automatic complete_run();
		if (miscompares == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog against a hang
	initial
	begin
		repeat (2000) @(posedge mclk_in);
		miscompares++;
		complete_run();
	end

	// Main sequence
	initial
	begin
		repeat (20) @(negedge mclk_in);
		srst_in = 1'b0;
		`CHK("reset cfg", 5'h01, {pm, iref, rng, neg})
		`CHK("reset idle", 4'h1, {busy, avail, oe, pwr})
		foreach (rows[i])
		begin
			host.write_cfg(rows[i].cs_n, rows[i].w);
			`CHK("cfg outputs", rows[i].e, {pm, iref, rng, neg})
		end
		// Fill the FIFO, ninth start refused
		host.write_cfg(1'b0, 12'h240);
		for (int i = 0; i < 9; i++)
		begin
			sar_code = 12'h123 + 12'(i * 273);
			host.start_conv();
			`CHK("busy", i < 8, busy)
			`CHK("hold", i < 8, hold)
			repeat (14) @(negedge mclk_in);
			`CHK("track", 2'h0, {busy, hold})
		end
		// Drain, extra read repeats the last word
		for (int i = 0; i < 9; i++)
		begin
			host.read_word(word);
			`CHK("result", (12'h123 + 12'(i < 8 ? i : 7) * 12'h111) ^ 12'h800, word)
			`CHK("channel", 2'h2, chan)
		end
		`CHK("drained", 1'b0, avail)
		// Sequencer up to channel two, binary coding
		host.write_cfg(1'b0, 12'h044);
		repeat (3)
		begin
			host.start_conv();
			repeat (14) @(negedge mclk_in);
		end
		for (int i = 0; i < 3; i++)
		begin
			host.read_word(word);
			`CHK("seq channel", 2'(i), chan)
			`CHK("binary", 12'h9AB, word)
		end
		`CHK("mux pos", 2'h2, mpos)
		`CHK("mux neg", 2'h0, mneg)
		// Auto power mode sleeps after a conversion, start rise wakes it
		host.write_cfg(1'b0, 12'h400);
		host.start_conv();
		repeat (14) @(negedge mclk_in);
		`CHK("asleep", 1'b0, pwr)
		host.start_conv();
		`CHK("still asleep", 1'b0, pwr)
		@(negedge mclk_in);
		`CHK("woken", 1'b1, pwr)
		repeat (13) @(negedge mclk_in);
		// Differential pair steering, then reset in mid-run clears the word
		host.write_cfg(1'b0, 12'h009);
		`CHK("diff mux", 4'h1, {mpos, mneg})
		@(negedge mclk_in);
		srst_in = 1'b1;
		@(negedge mclk_in);
		srst_in = 1'b0;
		`CHK("rerun cfg", 5'h01, {pm, iref, rng, neg})
		repeat (2) @(negedge mclk_in);
		`CHK("rerun idle", 3'h1, {busy, avail, pwr})
		complete_run();
	end
endmodule
